//--- hdl/nv_device.sv
// EEPROM byte access logic with its I/O registers, write timer and core stall.
`timescale 1ns/100ps
`default_nettype none
// Function
// R1 - Read trigger stalls core four cycles
// R2 - Write trigger stalls core two cycles
// R3 - Write in progress survives reset
// R4 - Bytes addressed linearly from zero
// R5 - Nine-bit address, upper bits read zero
// R6 - Address undefined at reset; software loads it
// R7 - Small variant: software writes bit eight zero
// R8 - Data register feeds writes, receives reads
// R9 - Writes need the arming sequence
// R10 - Write self-timed, completion visible
// R11 - Registers live in I/O space
// R12 - Low I/O addresses allow bit operations
// R13 - I/O instructions 0x00-0x3F, data space +0x20
// R14 - Extended area only by data-space access
// R15 - Bit operations change only named bit
// R16 - Some flags clear by writing one
// R17 - Software zeroes reserved bits, avoids reserved addresses
// R18 - Three general-purpose storage registers
// R19 - Arm opens four-cycle window, then self-clears
// R20 - Mode field selects erase/write and time
// R21 - Strobe clears when done; ready interrupt follows
// R22 - Busy blocks reads and address changes
// R23 - One stall signal, exact cycle count
// R24 - Read data loaded within stall period
module nv_device
  import nv_pkg::*;
#(
  parameter int DEPTH = NV_DEPTH,
  parameter int ATOMIC_CYCLES = ATOMIC_CYC,
  parameter int SPLIT_CYCLES = SPLIT_CYC
) (
  input wire logic core_clk,
  input wire logic rstn,
  nv_io_if.dev bus,
  output logic write_busy
);

  localparam int AW = $clog2(DEPTH);

  generate
    if (!(DEPTH == 256 || DEPTH == 512)) begin : g_bad_depth
      $error("nv_device: DEPTH must be 256 or 512");
    end
    if (ATOMIC_CYCLES < 2 || ATOMIC_CYCLES > 65535 || SPLIT_CYCLES < 2 ||
        SPLIT_CYCLES > 65535) begin : g_bad_time
      $error("nv_device: cycle counts must be 2..65535");
    end
  endgenerate

  localparam logic [15:0] ATOMIC_LOAD = 16'(ATOMIC_CYCLES);
  localparam logic [15:0] SPLIT_LOAD = 16'(SPLIT_CYCLES);
  localparam logic [5:0] GP_IDX [3] = '{IO_GP0, IO_GP1, IO_GP2};

  logic [7:0] mem [DEPTH];
  logic [8:0] nv_address;
  logic [7:0] nv_data_byte, wr_data, rd_data;
  logic [1:0] prog_mode, wr_mode;
  logic ready_irq_enable, write_strobe, done_flag;
  logic [2:0] arm_cnt, stall_cnt;
  logic [15:0] prog_cnt;
  logic [AW-1:0] wr_addr;
  logic [7:0] gp [3];

  logic [6:0] map;
  logic [5:0] idx;
  logic bitop, legal, wr_req, rd_req, ctrl_wr, start, rd_trig, prog_done;
  logic [7:0] rd_val, nv, ones;

  assign map = io_map(bus.acc_dspace, bus.acc_addr); // R13 R14
  assign idx = map[5:0];
  assign bitop = (bus.acc_kind == K_SET) || (bus.acc_kind == K_CLR);
  // Bit operations above I/O 0x1F are ignored.
  assign legal = bus.acc_valid && rstn && map[6] &&
                 (!bitop || bit_ok(bus.acc_dspace, bus.acc_addr)); // R12
  assign wr_req = legal && (bus.acc_kind != K_READ);
  assign rd_req = bus.acc_valid && rstn && (bus.acc_kind == K_READ);

  always_comb begin
    rd_val = 8'h00;
    if (idx == IO_CTRL) begin
      rd_val = {2'b00, prog_mode, ready_irq_enable, arm_cnt != 3'd0, write_strobe, 1'b0};
    end else if (idx == IO_DATA) begin
      rd_val = nv_data_byte;
    end else if (idx == IO_ADDR_LO) begin
      rd_val = nv_address[7:0];
    end else if (idx == IO_ADDR_HI) begin
      rd_val = {7'b0000000, nv_address[8]}; // R5
    end else if (idx == IO_STATUS) begin
      rd_val = {7'b0000000, done_flag};
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (idx == GP_IDX[i]) begin
          rd_val = gp[i];
        end
      end
    end
  end

  assign nv = upd(bus.acc_kind, rd_val, bus.acc_wdata, bus.acc_bit); // R15
  assign ones = ones_of(bus.acc_kind, bus.acc_wdata, bus.acc_bit);
  assign ctrl_wr = wr_req && (idx == IO_CTRL);
  assign start = ctrl_wr && ones[CTRL_STROBE] && (arm_cnt != 3'd0) && !write_strobe &&
                 (nv[CTRL_MODE_HI:CTRL_MODE_LO] != MODE_RSVD); // R9 R19 R20
  assign rd_trig = ctrl_wr && ones[CTRL_READ] && !write_strobe; // R22
  assign prog_done = write_strobe && (prog_cnt == 16'd1);

  // Reads answer one cycle later; unmapped and extended locations read zero.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      rd_data <= 8'h00;
    end else if (rd_req) begin
      rd_data <= map[6] ? rd_val : 8'h00; // R11 R14
    end
  end

  // Write engine; a reset during programming leaves it running.
  always_ff @(posedge core_clk) begin
    if (write_strobe) begin
      if (prog_done) begin
        write_strobe <= 1'b0; // R21 R10
      end
      prog_cnt <= prog_cnt - 16'd1; // R3
    end else if (!rstn) begin
      write_strobe <= 1'b0;
      prog_cnt <= 16'd0;
      wr_mode <= MODE_RESET;
    end else if (start) begin
      write_strobe <= 1'b1;
      wr_mode <= nv[CTRL_MODE_HI:CTRL_MODE_LO];
      wr_addr <= nv_address[AW-1:0]; // R4
      wr_data <= nv_data_byte; // R8
      prog_cnt <= (nv[CTRL_MODE_HI:CTRL_MODE_LO] == MODE_ERASE_WRITE) ?
                  ATOMIC_LOAD : SPLIT_LOAD; // R20
    end
  end

  always_ff @(posedge core_clk) begin
    if (prog_done) begin
      unique case (wr_mode)
        MODE_ERASE_WRITE: mem[wr_addr] <= wr_data; // R20
        MODE_ERASE: mem[wr_addr] <= ERASED_BYTE;
        MODE_WRITE: mem[wr_addr] <= mem[wr_addr] & wr_data;
        default: mem[wr_addr] <= mem[wr_addr];
      endcase
    end
  end

  // Mode field is frozen while programming and resets only when idle.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      if (!write_strobe) begin
        prog_mode <= MODE_RESET; // R3
      end
    end else if (ctrl_wr && !write_strobe) begin
      prog_mode <= nv[CTRL_MODE_HI:CTRL_MODE_LO];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      ready_irq_enable <= 1'b0;
    end else if (ctrl_wr) begin
      ready_irq_enable <= nv[CTRL_IRQEN];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      arm_cnt <= 3'd0;
    end else if (start) begin
      arm_cnt <= 3'd0; // R19
    end else if (ctrl_wr && ones[CTRL_ARM]) begin
      arm_cnt <= ARM_WINDOW; // R19
    end else if (arm_cnt != 3'd0) begin
      arm_cnt <= arm_cnt - 3'd1;
    end
  end

  // Address has no reset value and is locked during programming.
  always_ff @(posedge core_clk) begin
    if (rstn && wr_req && !write_strobe) begin
      if (idx == IO_ADDR_LO) begin
        nv_address[7:0] <= nv; // R6 R22
      end
      if (idx == IO_ADDR_HI) begin
        nv_address[8] <= nv[0]; // R5
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      nv_data_byte <= DATA_RESET;
    end else if (rd_trig) begin
      nv_data_byte <= mem[nv_address[AW-1:0]]; // R24 R8
    end else if (wr_req && (idx == IO_DATA)) begin
      nv_data_byte <= nv;
    end
  end

  // Write-one-to-clear flag; a completing write wins.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      done_flag <= 1'b0;
    end else if (prog_done) begin
      done_flag <= 1'b1;
    end else if (wr_req && (idx == IO_STATUS) && ones[STATUS_DONE]) begin
      done_flag <= 1'b0; // R16
    end
  end

  generate
    for (genvar g = 0; g < 3; g++) begin : g_gp
      always_ff @(posedge core_clk) begin
        if (!rstn) begin
          gp[g] <= GP_RESET;
        end else if (wr_req && (idx == GP_IDX[g])) begin
          gp[g] <= nv; // R18
        end
      end
    end
  endgenerate

  // A read trigger dominates when both triggers share one access.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      stall_cnt <= 3'd0;
    end else if (rd_trig) begin
      stall_cnt <= READ_STALL; // R1
    end else if (start) begin
      stall_cnt <= WRITE_STALL; // R2
    end else if (stall_cnt != 3'd0) begin
      stall_cnt <= stall_cnt - 3'd1;
    end
  end

  assign bus.stall = stall_cnt != 3'd0; // R23
  assign bus.acc_rdata = rd_data;
  assign bus.ready_irq = ready_irq_enable && !write_strobe; // R21
  assign write_busy = write_strobe;

endmodule // nv_device
`default_nettype wire

//--- inc/nv_pkg.sv
// Constants, types and decode functions of the EEPROM byte access logic.
package nv_pkg;

  typedef enum logic [3:0] {
    K_READ = 4'b0001,
    K_WRITE = 4'b0010,
    K_SET = 4'b0100,
    K_CLR = 4'b1000
  } kind_t;

  typedef enum logic [6:0] {
    OP_IN = 7'b0000001,
    OP_OUT = 7'b0000010,
    OP_LD = 7'b0000100,
    OP_ST = 7'b0001000,
    OP_SBI = 7'b0010000,
    OP_CBI = 7'b0100000,
    OP_BTST = 7'b1000000
  } op_t;

  localparam int NV_DEPTH = 512;

  localparam logic [5:0] IO_STATUS = 6'h1d;
  localparam logic [5:0] IO_GP0 = 6'h1e;
  localparam logic [5:0] IO_CTRL = 6'h1f;
  localparam logic [5:0] IO_DATA = 6'h20;
  localparam logic [5:0] IO_ADDR_LO = 6'h21;
  localparam logic [5:0] IO_ADDR_HI = 6'h22;
  localparam logic [5:0] IO_GP1 = 6'h2a;
  localparam logic [5:0] IO_GP2 = 6'h2b;

  localparam logic [7:0] BIT_IO_MAX = 8'h1f;
  localparam logic [7:0] IO_MAX = 8'h3f;
  localparam logic [7:0] DSPACE_OFS = 8'h20;
  localparam logic [7:0] EXT_LO = 8'h60;

  localparam int CTRL_READ = 0;
  localparam int CTRL_STROBE = 1;
  localparam int CTRL_ARM = 2;
  localparam int CTRL_IRQEN = 3;
  localparam int CTRL_MODE_LO = 4;
  localparam int CTRL_MODE_HI = 5;
  localparam logic [7:0] CTRL_WMASK = 8'h3f;
  localparam int STATUS_DONE = 0;

  localparam logic [1:0] MODE_ERASE_WRITE = 2'b00;
  localparam logic [1:0] MODE_ERASE = 2'b01;
  localparam logic [1:0] MODE_WRITE = 2'b10;
  localparam logic [1:0] MODE_RSVD = 2'b11;

  localparam logic [1:0] MODE_RESET = 2'b00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] GP_RESET = 8'h00;
  localparam logic [7:0] ERASED_BYTE = 8'hff;

  localparam int CLK_PERIOD_NS = 100;
  localparam int T_ATOMIC_US = 3400;
  localparam int T_SPLIT_US = 1800;
  localparam int ATOMIC_CYC = (T_ATOMIC_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SPLIT_CYC = (T_SPLIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] READ_STALL = 3'd4;
  localparam logic [2:0] WRITE_STALL = 3'd2;
  localparam logic [2:0] ARM_WINDOW = 3'd4;

  // Returns {hit, io_index} of an access address.
  function automatic logic [6:0] io_map(input logic dspace, input logic [7:0] a);
    logic [7:0] off;
    off = a - DSPACE_OFS;
    if (dspace) begin
      io_map = {(a >= DSPACE_OFS) && (a < EXT_LO), off[5:0]};
    end else begin
      io_map = {a <= IO_MAX, a[5:0]};
    end
  endfunction

  function automatic logic bit_ok(input logic dspace, input logic [7:0] a);
    bit_ok = !dspace && (a <= BIT_IO_MAX);
  endfunction

  function automatic logic reg_known(input logic [5:0] idx);
    reg_known = (idx == IO_STATUS) || (idx == IO_GP0) || (idx == IO_CTRL) ||
                (idx == IO_DATA) || (idx == IO_ADDR_LO) || (idx == IO_ADDR_HI) ||
                (idx == IO_GP1) || (idx == IO_GP2);
  endfunction

  // Bit operations touch one bit only.
  function automatic logic [7:0] upd(input kind_t k, input logic [7:0] cur,
                                     input logic [7:0] wd, input logic [2:0] b);
    logic [7:0] m;
    m = 8'h01 << b;
    unique case (k)
      K_WRITE: upd = wd;
      K_SET: upd = cur | m;
      K_CLR: upd = cur & ~m;
      K_READ: upd = cur;
    endcase
  endfunction

  function automatic logic [7:0] ones_of(input kind_t k, input logic [7:0] wd,
                                         input logic [2:0] b);
    unique case (k)
      K_WRITE: ones_of = wd;
      K_SET: ones_of = 8'h01 << b;
      K_CLR: ones_of = 8'h00;
      K_READ: ones_of = 8'h00;
    endcase
  endfunction

endpackage

//--- inc/nv_io_if.sv
// I/O access channel between the processor core and the EEPROM access logic.
`timescale 1ns/100ps
`default_nettype none
interface nv_io_if;
  import nv_pkg::*;
  logic acc_valid;
  kind_t acc_kind;
  logic acc_dspace;
  logic [7:0] acc_addr;
  logic [2:0] acc_bit;
  logic [7:0] acc_wdata;
  logic [7:0] acc_rdata;
  logic stall;
  logic ready_irq;

  modport dev(input acc_valid, acc_kind, acc_dspace, acc_addr, acc_bit, acc_wdata,
              output acc_rdata, stall, ready_irq);
  modport cpu(output acc_valid, acc_kind, acc_dspace, acc_addr, acc_bit, acc_wdata,
              input acc_rdata, stall, ready_irq);
endinterface
`default_nettype wire

//--- hdl/nv_host.sv
// Processor-side issuer of I/O instructions towards the EEPROM access logic.
`timescale 1ns/100ps
`default_nettype none
module nv_host
  import nv_pkg::*;
#(
  parameter int DEPTH = NV_DEPTH
) (
  input wire logic core_clk,
  input wire logic rstn,
  nv_io_if.cpu bus,
  input wire logic req_valid,
  output logic req_ready,
  input wire op_t req_op,
  input wire logic [7:0] req_addr,
  input wire logic [2:0] req_bit,
  input wire logic [7:0] req_wdata,
  output logic resp_valid,
  output logic [7:0] resp_data,
  output logic resp_bit,
  output logic resp_err,
  output logic irq_req
);

  generate
    if (!(DEPTH == 256 || DEPTH == 512)) begin : g_bad_depth
      $error("nv_host: DEPTH must be 256 or 512");
    end
  endgenerate

  typedef enum logic [2:0] {
    H_IDLE = 3'b001,
    H_ISSUE = 3'b010,
    H_WAIT = 3'b100
  } hstate_t;

  hstate_t st;
  logic a_dspace, addr_loaded, dspace, is_bitop, is_wr, bad;
  logic [7:0] a_addr, a_wdata, ones, clean;
  kind_t a_kind, kind;
  logic [2:0] a_bit;
  logic [6:0] map;

  always_comb begin
    dspace = (req_op == OP_LD) || (req_op == OP_ST);
    unique case (req_op)
      OP_OUT, OP_ST: kind = K_WRITE;
      OP_SBI: kind = K_SET;
      OP_CBI: kind = K_CLR;
      default: kind = K_READ;
    endcase
    map = io_map(dspace, req_addr);
    is_bitop = (req_op == OP_SBI) || (req_op == OP_CBI) || (req_op == OP_BTST);
    is_wr = kind != K_READ;
    ones = ones_of(kind, req_wdata, req_bit);
    // Reserved bits of control and address-high writes go out as zero; status writes pass unmasked.
    clean = req_wdata;
    if (map[5:0] == IO_CTRL) begin
      clean = req_wdata & CTRL_WMASK; // R17
    end else if (map[5:0] == IO_ADDR_HI) begin
      clean = {7'b0000000, req_wdata[0] && (DEPTH != 256)}; // R7
    end
    bad = 1'b0;
    if (!dspace && !map[6]) begin
      bad = 1'b1; // R13
    end
    if (is_bitop && !bit_ok(dspace, req_addr)) begin
      bad = 1'b1; // R12
    end
    if (is_wr && !(map[6] && reg_known(map[5:0]))) begin
      bad = 1'b1; // R17
    end
    if (is_wr && (map[5:0] == IO_CTRL) && !addr_loaded &&
        (ones[CTRL_READ] || ones[CTRL_STROBE])) begin
      bad = 1'b1; // R6
    end
    if ((DEPTH == 256) && (req_op == OP_SBI) && (map[5:0] == IO_ADDR_HI) &&
        (req_bit == 3'd0)) begin
      bad = 1'b1; // R7
    end
  end

  assign req_ready = st == H_IDLE;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      st <= H_IDLE;
    end else begin
      unique case (st)
        H_IDLE: begin
          if (req_valid && !bad) begin
            st <= H_ISSUE;
          end
        end
        H_ISSUE: st <= H_WAIT;
        H_WAIT: begin
          if (!bus.stall) begin
            st <= H_IDLE; // R1 R2
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      a_dspace <= 1'b0;
      a_addr <= 8'h00;
      a_kind <= K_READ;
      a_bit <= 3'd0;
      a_wdata <= 8'h00;
    end else if ((st == H_IDLE) && req_valid && !bad) begin
      a_dspace <= dspace;
      a_addr <= req_addr;
      a_kind <= kind;
      a_bit <= req_bit;
      a_wdata <= clean;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      addr_loaded <= 1'b0;
    end else if ((st == H_IDLE) && req_valid && !bad && is_wr && map[6] &&
                 (map[5:0] == IO_ADDR_LO)) begin
      addr_loaded <= 1'b1; // R6
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      resp_valid <= 1'b0;
      resp_err <= 1'b0;
      resp_data <= 8'h00;
      resp_bit <= 1'b0;
    end else begin
      resp_valid <= 1'b0;
      if ((st == H_IDLE) && req_valid && bad) begin
        resp_valid <= 1'b1;
        resp_err <= 1'b1;
        resp_data <= 8'h00;
        resp_bit <= 1'b0;
      end else if ((st == H_WAIT) && !bus.stall) begin
        resp_valid <= 1'b1;
        resp_err <= 1'b0;
        resp_data <= bus.acc_rdata;
        resp_bit <= bus.acc_rdata[a_bit];
      end
    end
  end

  assign bus.acc_valid = st == H_ISSUE;
  assign bus.acc_dspace = a_dspace;
  assign bus.acc_addr = a_addr;
  assign bus.acc_kind = a_kind;
  assign bus.acc_bit = a_bit;
  assign bus.acc_wdata = a_wdata;
  assign irq_req = bus.ready_irq; // R21

endmodule // nv_host
`default_nettype wire

//--- bench/nv_sva.sv
// Concurrent checks on the core-to-EEPROM access channel.
`timescale 1ns/100ps
`default_nettype none
module nv_sva
  import nv_pkg::*;
#(
  parameter int ATOMIC_CYCLES = ATOMIC_CYC,
  parameter int SPLIT_CYCLES = SPLIT_CYC
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic acc_valid,
  input wire kind_t acc_kind,
  input wire logic acc_dspace,
  input wire logic [7:0] acc_addr,
  input wire logic [2:0] acc_bit,
  input wire logic [7:0] acc_wdata,
  input wire logic [7:0] acc_rdata,
  input wire logic stall,
  input wire logic ready_irq,
  input wire logic write_busy
);
  logic ctrl_w, rd_trig, strobe_w, start;
  logic [2:0] arm_left;
  logic [1:0] mode_l;
  int busy_cnt, exp_len;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  assign ctrl_w = rstn && acc_valid && (acc_kind == K_WRITE) &&
                  (acc_addr == ({2'b00, IO_CTRL} + (acc_dspace ? DSPACE_OFS : 8'h00)));
  assign rd_trig = ctrl_w && acc_wdata[CTRL_READ] && !acc_wdata[CTRL_STROBE] && !write_busy;
  assign strobe_w = ctrl_w && acc_wdata[CTRL_STROBE] && !acc_wdata[CTRL_READ] && !write_busy;
  assign start = strobe_w && (arm_left != 3'd0) && (acc_wdata[5:4] != MODE_RSVD);
  assign exp_len = (mode_l == MODE_ERASE_WRITE) ? ATOMIC_CYCLES : SPLIT_CYCLES;
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      arm_left <= 3'd0;
    end else if (ctrl_w && acc_wdata[CTRL_ARM] && !acc_wdata[CTRL_STROBE]) begin
      arm_left <= ARM_WINDOW;
    end else if (ctrl_w && acc_wdata[CTRL_STROBE]) begin
      arm_left <= 3'd0;
    end else if (arm_left != 3'd0) begin
      arm_left <= arm_left - 3'd1;
    end
  end
  // Programming runs on through reset, so these two ignore it.
  always_ff @(posedge core_clk) begin
    if (start) begin
      mode_l <= acc_wdata[5:4];
    end
  end
  always_ff @(posedge core_clk) begin
    busy_cnt <= write_busy ? busy_cnt + 1 : 0;
  end
  a_read_stall_four: assert property (rd_trig |=> stall [*4] ##1 !stall)
    else $error("read stall length wrong");
  a_write_stall_two: assert property (start |=> write_busy && stall ##1 stall ##1 !stall)
    else $error("write stall length wrong");
  a_busy_time_exact: assert property ($fell(write_busy) |-> busy_cnt == exp_len)
    else $error("programming time wrong");
  a_strobe_needs_arm: assert property (strobe_w && arm_left == 3'd0 |=> !stall && !write_busy)
    else $error("write started without arm");
  a_mode_rsvd_ignored: assert property (strobe_w && acc_wdata[5:4] == MODE_RSVD |=> !stall)
    else $error("reserved mode started a write");
  a_busy_read_ignored: assert property (ctrl_w && acc_wdata[CTRL_READ] && write_busy |=> !stall)
    else $error("read accepted while busy");
  a_irq_quiet_busy: assert property (write_busy |-> !ready_irq)
    else $error("ready request while busy");
  a_stall_has_cause: assert property ($rose(stall) |-> $past(ctrl_w))
    else $error("stall without trigger");
  a_rdata_holds: assert property (!(acc_valid && acc_kind == K_READ) |=> $stable(acc_rdata))
    else $error("read data changed without read");
  a_ext_reads_zero: assert property (acc_valid && acc_kind == K_READ && acc_dspace &&
    acc_addr >= EXT_LO |=> acc_rdata == 8'h00)
    else $error("extended area read not zero");
  c_read: cover property (rd_trig);
  c_start: cover property (start);
  c_irq: cover property ($rose(ready_irq));
  c_reset_busy: cover property (disable iff (1'b0) write_busy && !rstn);
endmodule // nv_sva
`default_nettype wire

//--- bench/eeprom_byte_access_tb.sv
// Self-checking bench for both ends of the EEPROM byte access logic.
`timescale 1ns/100ps
`default_nettype none
module eeprom_byte_access_tb
  import nv_pkg::*;
;
  localparam int AC = 20, SC = 10;
  logic core_clk = 1'b0, rstn = 1'b0, req_valid = 1'b0;
  op_t req_op = OP_IN;
  logic [7:0] req_addr = 8'h00;
  logic [2:0] req_bit = 3'd0;
  logic [7:0] req_wdata = 8'h00;
  logic req_ready, resp_valid, resp_bit, resp_err, irq_req, write_busy, busy2, er, rb;
  logic [7:0] resp_data, rd;
  int lat, ws, rs, err_total = 0, check_count = 0, st_cnt = 0;
  nv_io_if bus0 ();
  nv_io_if bus1 ();
  always #50 core_clk = ~core_clk;
  always @(posedge core_clk) if (bus0.stall === 1'b1) st_cnt++;
  nv_host nv_host_inst (.core_clk(core_clk), .rstn(rstn), .bus(bus0.cpu),
    .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op), .req_addr(req_addr),
    .req_bit(req_bit), .req_wdata(req_wdata), .resp_valid(resp_valid), .resp_data(resp_data),
    .resp_bit(resp_bit), .resp_err(resp_err), .irq_req(irq_req));
  nv_device #(.ATOMIC_CYCLES(AC), .SPLIT_CYCLES(SC)) nv_device_inst (
    .core_clk(core_clk), .rstn(rstn), .bus(bus0.dev), .write_busy(write_busy));
  nv_device #(.ATOMIC_CYCLES(AC), .SPLIT_CYCLES(SC)) nv_device_inst2 (
    .core_clk(core_clk), .rstn(rstn), .bus(bus1.dev), .write_busy(busy2));
  nv_sva #(.ATOMIC_CYCLES(AC), .SPLIT_CYCLES(SC)) nv_sva_inst (.core_clk(core_clk), .rstn(rstn),
    .acc_valid(bus0.acc_valid), .acc_kind(bus0.acc_kind), .acc_dspace(bus0.acc_dspace),
    .acc_addr(bus0.acc_addr), .acc_bit(bus0.acc_bit), .acc_wdata(bus0.acc_wdata),
    .acc_rdata(bus0.acc_rdata), .stall(bus0.stall), .ready_irq(bus0.ready_irq),
    .write_busy(write_busy));
  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #10;
  endtask
  task automatic io(input op_t op, input logic [7:0] a, input logic [7:0] d,
                    input logic [2:0] b = 3'd0);
    check("ready", req_ready, 1'b1);
    req_valid = 1'b1;
    req_op = op;
    req_addr = a;
    req_wdata = d;
    req_bit = b;
    step(1);
    req_valid = 1'b0;
    lat = 1;
    while (resp_valid !== 1'b1 && lat < 80) begin
      step(1);
      lat++;
    end
    check("response", resp_valid, 1'b1);
    rd = resp_data;
    er = resp_err;
    rb = resp_bit;
  endtask
  task automatic wait_idle();
    int n = 0;
    while (write_busy !== 1'b0 && n < 60) begin
      step(1);
      n++;
    end
    check("busy end", write_busy, 1'b0);
  endtask
  task automatic ewrite(input logic [8:0] a, input logic [7:0] d, input logic [1:0] m,
                        input logic ie);
    io(OP_OUT, 8'h21, a[7:0]);
    io(OP_OUT, 8'h22, {7'h00, a[8]});
    io(OP_OUT, 8'h20, d);
    io(OP_OUT, 8'h1f, {2'b00, m, ie, 3'b100});
    st_cnt = 0;
    io(OP_OUT, 8'h1f, {2'b00, m, ie, 3'b010});
    ws = st_cnt;
  endtask
  task automatic eread(input logic [8:0] a);
    io(OP_OUT, 8'h21, a[7:0]);
    io(OP_OUT, 8'h22, {7'h00, a[8]});
    st_cnt = 0;
    io(OP_OUT, 8'h1f, 8'h01);
    rs = st_cnt;
    io(OP_IN, 8'h20, 8'h00);
  endtask
  task automatic dacc(input kind_t k, input logic ds, input logic [7:0] a, input logic [7:0] d,
                      input logic [2:0] b = 3'd0);
    bus1.acc_valid = 1'b1;
    bus1.acc_kind = k;
    bus1.acc_dspace = ds;
    bus1.acc_addr = a;
    bus1.acc_wdata = d;
    bus1.acc_bit = b;
    step(1);
    bus1.acc_valid = 1'b0;
    step(1);
  endtask
  task automatic t_regs();
    io(OP_OUT, 8'h1e, 8'ha1);
    io(OP_OUT, 8'h2a, 8'ha2);
    io(OP_OUT, 8'h2b, 8'ha3);
    io(OP_IN, 8'h2b, 8'h00);
    check("gp2", rd, 8'ha3);
    io(OP_ST, 8'h3e, 8'h44);
    io(OP_IN, 8'h1e, 8'h00);
    check("st gp0", rd, 8'h44);
    io(OP_LD, 8'h4a, 8'h00);
    check("ld gp1", rd, 8'ha2);
    io(OP_IN, 8'h40, 8'h00);
    check("in 40", er, 1'b1);
    io(OP_LD, 8'h60, 8'h00);
    check("ld ext", {er, rd}, 9'h000);
    io(OP_OUT, 8'h22, 8'hff);
    io(OP_IN, 8'h22, 8'h00);
    check("addr hi", rd, 8'h01);
    io(OP_OUT, 8'h23, 8'h55);
    check("rsvd", er, 1'b1);
    io(OP_SBI, 8'h1e, 8'h00, 3'd7);
    io(OP_CBI, 8'h1e, 8'h00, 3'd2);
    io(OP_IN, 8'h1e, 8'h00);
    check("bit ops", rd, 8'hc0);
    io(OP_BTST, 8'h1e, 8'h00, 3'd6);
    check("bit test", rb, 1'b1);
    io(OP_SBI, 8'h2a, 8'h00, 3'd0);
    check("sbi high", er, 1'b1);
    $display("test t_regs done");
  endtask
  task automatic t_modes();
    logic [8:0] ta [4] = '{9'h1ff, 9'h1ff, 9'h1ff, 9'h000};
    logic [7:0] td [4] = '{8'h5a, 8'h0f, 8'h00, 8'ha5};
    logic [1:0] tm [4] = '{MODE_ERASE_WRITE, MODE_WRITE, MODE_ERASE, MODE_ERASE_WRITE};
    logic [7:0] te [4] = '{8'h5a, 8'h0a, 8'hff, 8'ha5};
    for (int i = 0; i < 4; i++) begin
      ewrite(ta[i], td[i], tm[i], 1'b0);
      check("write stall", ws, 2);
      check("busy", write_busy, 1'b1);
      wait_idle();
      eread(ta[i]);
      check("read stall", rs, 4);
      check("read byte", rd, te[i]);
    end
    eread(9'h1ff);
    check("other byte", rd, 8'hff);
    io(OP_IN, 8'h1d, 8'h00);
    check("done", rd[0], 1'b1);
    io(OP_CBI, 8'h1d, 8'h00, 3'd1);
    io(OP_IN, 8'h1d, 8'h00);
    check("cbi keeps", rd[0], 1'b1);
    io(OP_SBI, 8'h1d, 8'h00, 3'd0);
    io(OP_IN, 8'h1d, 8'h00);
    check("one clears", rd[0], 1'b0);
    $display("test t_modes done");
  endtask
  task automatic t_guards();
    ewrite(9'h055, 8'h11, MODE_ERASE_WRITE, 1'b0);
    io(OP_IN, 8'h1f, 8'h00);
    check("arm clear", rd[2], 1'b0);
    wait_idle();
    io(OP_OUT, 8'h20, 8'h22);
    st_cnt = 0;
    io(OP_OUT, 8'h1f, 8'h02);
    check("no arm", {st_cnt[3:0], write_busy}, 5'h00);
    io(OP_OUT, 8'h1f, 8'h04);
    io(OP_IN, 8'h1e, 8'h00);
    io(OP_IN, 8'h1e, 8'h00);
    io(OP_OUT, 8'h1f, 8'h02);
    check("late strobe", {st_cnt[3:0], write_busy}, 5'h00);
    io(OP_OUT, 8'h1f, 8'h34);
    io(OP_OUT, 8'h1f, 8'h32);
    check("mode 11", {st_cnt[3:0], write_busy}, 5'h00);
    eread(9'h055);
    check("kept", rd, 8'h11);
    $display("test t_guards done");
  endtask
  task automatic t_busy();
    ewrite(9'h0aa, 8'h77, MODE_ERASE_WRITE, 1'b1);
    check("irq busy", irq_req, 1'b0);
    io(OP_OUT, 8'h21, 8'h33);
    st_cnt = 0;
    io(OP_OUT, 8'h1f, 8'h09);
    check("busy read", st_cnt, 0);
    io(OP_IN, 8'h21, 8'h00);
    check("addr kept", rd, 8'haa);
    wait_idle();
    check("irq", irq_req, 1'b1);
    eread(9'h0aa);
    check("busy byte", {irq_req, rd}, 9'h077);
    $display("test t_busy done");
  endtask
  task automatic t_reset();
    ewrite(9'h010, 8'h3c, MODE_ERASE_WRITE, 1'b0);
    step(3);
    rstn = 1'b0;
    step(2);
    rstn = 1'b1;
    check("busy kept", write_busy, 1'b1);
    wait_idle();
    eread(9'h010);
    check("reset write", rd, 8'h3c);
    $display("test t_reset done");
  endtask
  task automatic t_direct();
    dacc(K_WRITE, 1'b0, 8'h1e, 8'h81);
    dacc(K_SET, 1'b1, 8'h3e, 8'h00, 3'd1);
    dacc(K_SET, 1'b0, 8'h2a, 8'h00, 3'd0);
    dacc(K_READ, 1'b0, 8'h1e, 8'h00);
    check("dev gp0", bus1.acc_rdata, 8'h81);
    dacc(K_READ, 1'b0, 8'h2a, 8'h00);
    check("dev gp1", bus1.acc_rdata, GP_RESET);
    dacc(K_WRITE, 1'b0, 8'h23, 8'h55);
    dacc(K_READ, 1'b0, 8'h23, 8'h00);
    check("dev rsvd", bus1.acc_rdata, 8'h00);
    dacc(K_WRITE, 1'b0, 8'h22, 8'h00);
    dacc(K_WRITE, 1'b0, 8'h62, 8'h01);
    dacc(K_READ, 1'b0, 8'h22, 8'h00);
    check("dev io range", bus1.acc_rdata, 8'h00);
    dacc(K_WRITE, 1'b1, 8'h42, 8'hff);
    dacc(K_READ, 1'b1, 8'h42, 8'h00);
    check("dev addr hi", bus1.acc_rdata, 8'h01);
    $display("test t_direct done");
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    bus1.acc_valid = 1'b0;
    bus1.acc_kind = K_READ;
    bus1.acc_dspace = 1'b0;
    bus1.acc_addr = 8'h00;
    bus1.acc_bit = 3'd0;
    bus1.acc_wdata = 8'h00;
    step(6);
    rstn = 1'b1;
    t_regs();
    t_modes();
    t_guards();
    t_busy();
    t_reset();
    t_direct();
    print_verdict();
  end
  initial begin
    #(6000 * 100);
    err_total++;
    $display("watchdog expired");
    print_verdict();
  end
endmodule // eeprom_byte_access_tb
`default_nettype wire
